// ### src/sfrs_pkg.sv
// Purpose: shared constants for the serial flash read sequencer
// Assumes: flash driven with SPI mode 0 style clock derived from core_clk
// Notes:   opcodes are package constants
package sfrs_pkg;
  localparam int ADDR_W       = 24;
  localparam int DATA_W       = 8;
  localparam int BYTE_CYCLES  = 8;
  localparam int FAST_EXTRA   = 8;
  localparam int CMD_BITS     = 8;
  localparam int ADDR_BITS    = 24;
  localparam int SID_DUMMY    = 24;
  localparam int CNT_W        = 6;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_SID  = 8'hAB;
  localparam logic [7:0] ZERO8   = 8'h00;
  typedef enum logic [2:0] {SFRS_IDLE, SFRS_CMD, SFRS_ADR, SFRS_DUMMY, SFRS_DATA, SFRS_DONE} sfrs_state_t;
endpackage

// ### src/sfrs_shift.sv
// Purpose: shift register for serial out and in
// Assumes: one bit per core_clk cycle
// Notes:   msb first
`timescale 1ns/1ps
module sfrs_shift #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         shift,
  input  wire logic         ser_in,
  // data
  output logic [W-1:0]      val_reg
);
  always_ff @(posedge core_clk) begin
    if (srst) val_reg <= '0;
    else if (load) val_reg <= load_val;
    else if (shift) val_reg <= {val_reg[W-2:0], ser_in};
  end
endmodule // sfrs_shift

// ### src/sfrs_top.sv
// Purpose: command sequencer reading a serial flash over parallel ports
// Assumes: host keeps request and continue stable at clock edges
// Notes:   flash clock is core_clk gated by chip select
//
// Functional notes
// - id request sampled, busy held during
// - ident value valid before busy falls
// - ident output held until next ident read
// - request still high at end reruns
// - read request sampled, busy raised
// - one-cycle valid per byte
// - optional byte location output
// - continue high keeps reading sequentially
// - new byte every eight cycles
// - one more byte, then busy falls
// - last byte held until new read
// - fast read uses same handshakes
// - fast read first byte eight later
// - build selects normal or fast read
// - priority id, then read or fast per build
`timescale 1ns/1ps
module sfrs_top #(
  parameter bit USE_FAST  = 1'b0,
  parameter bit ADDR_OUT  = 1'b1
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // host requests
  input  wire logic                 read_sid_req,
  input  wire logic                 read_req,
  input  wire logic                 fast_read_req,
  input  wire logic                 read_cont,
  input  wire logic [sfrs_pkg::ADDR_W-1:0] addr_in,
  // host results
  output logic                      busy,
  output logic                      byte_valid,
  output logic [sfrs_pkg::DATA_W-1:0] byte_out,
  output logic [sfrs_pkg::ADDR_W-1:0] byte_loc,
  output logic [sfrs_pkg::DATA_W-1:0] silicon_ident_out,
  // flash pins
  output logic                      flash_cs_n,
  output logic                      flash_sclk_en,
  output logic                      flash_mosi,
  input  wire logic                 flash_miso
);
  import sfrs_pkg::*;

  // ==========================================
  // request decode
  sfrs_state_t           state_reg, state_next;
  logic [CNT_W-1:0]      cnt_reg;
  logic                  is_sid_reg;
  logic                  cont_reg;
  logic [ADDR_W-1:0]     loc_reg;
  logic [31:0]           sh_val;
  logic                  sh_load;
  logic [31:0]           sh_load_val;
  logic                  sh_shift;
  logic                  miso_reg;
  logic                  take_reg;
  // build picks normal or fast
  wire rd_req   = USE_FAST ? 1'b0 : read_req;
  wire fr_req   = USE_FAST ? fast_read_req : 1'b0;
  // priority id, then read or fast per build
  wire take_sid = read_sid_req;
  wire take_rd  = !read_sid_req && (rd_req || fr_req);
  // idle and busy low: one quiet cycle after each command
  wire start    = (state_reg == SFRS_IDLE) && !busy && (take_sid || take_rd);
  wire [7:0] op = take_sid ? OP_SID : (USE_FAST ? OP_FAST : OP_READ);
  wire cnt_last = (cnt_reg == CNT_W'(0));
  wire byte_end = (state_reg == SFRS_DATA) && cnt_last;
  // miso passes a flop, so the last bit is in one cycle after byte_end
  wire take_data  = take_reg && !is_sid_reg;
  wire take_ident = take_reg && is_sid_reg;
  wire [7:0] rx_byte = {sh_val[6:0], miso_reg};

  // ==========================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFRS_IDLE:  if (start) state_next = SFRS_CMD;
      SFRS_CMD:   if (cnt_last) state_next = SFRS_ADR;
      SFRS_ADR:   if (cnt_last) state_next = (USE_FAST && !is_sid_reg) ? SFRS_DUMMY : SFRS_DATA;
      SFRS_DUMMY: if (cnt_last) state_next = SFRS_DATA;
      SFRS_DATA:  if (cnt_last && (is_sid_reg || !cont_reg)) state_next = SFRS_DONE;
      SFRS_DONE:  state_next = SFRS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg  <= SFRS_IDLE;
      cnt_reg    <= '0;
      is_sid_reg <= 1'b0;
      cont_reg   <= 1'b0;
      miso_reg   <= 1'b0;
      take_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      miso_reg  <= flash_miso;
      take_reg  <= byte_end;
      if (start) begin
        is_sid_reg <= take_sid;
        cont_reg   <= read_cont;
      end else if (state_reg != SFRS_IDLE && !read_cont) begin
        cont_reg <= 1'b0;
      end
      if (start) cnt_reg <= CNT_W'(CMD_BITS - 1);
      else if (state_reg != state_next) begin
        unique case (state_next)
          SFRS_ADR:   cnt_reg <= CNT_W'(is_sid_reg ? SID_DUMMY - 1 : ADDR_BITS - 1);
          SFRS_DUMMY: cnt_reg <= CNT_W'(FAST_EXTRA - 1);
          SFRS_DATA:  cnt_reg <= CNT_W'(BYTE_CYCLES - 1);
          default:    cnt_reg <= '0;
        endcase
      end else if (cnt_last) cnt_reg <= CNT_W'(BYTE_CYCLES - 1);
      else cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // ==========================================
  // serial shifter
  assign sh_load     = start || (state_reg == SFRS_CMD && cnt_last);
  // address from the captured start location, not the live input
  assign sh_load_val = start ? {op, 24'h00_0000} : {loc_reg, 8'h00};
  assign sh_shift    = state_reg != SFRS_IDLE;

  sfrs_shift #(.W(32)) u_shift (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (sh_load),
    .load_val (sh_load_val),
    .shift    (sh_shift),
    .ser_in   (miso_reg),
    .val_reg  (sh_val)
  );

  // ==========================================
  // outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy              <= 1'b0;
      byte_valid        <= 1'b0;
      byte_out          <= ZERO8;
      silicon_ident_out <= ZERO8;
      byte_loc          <= '0;
      loc_reg           <= '0;
      flash_cs_n        <= 1'b1;
      flash_sclk_en     <= 1'b0;
      flash_mosi        <= 1'b0;
    end else begin
      // held through done so the last strobe sits inside busy
      busy          <= (state_next != SFRS_IDLE) || (state_reg == SFRS_DONE);
      flash_cs_n    <= (state_next == SFRS_IDLE) || (state_next == SFRS_DONE);
      flash_sclk_en <= (state_next != SFRS_IDLE) && (state_next != SFRS_DONE);
      flash_mosi    <= sh_load ? sh_load_val[31] : sh_val[30];
      if (start) loc_reg <= addr_in;
      byte_valid <= take_data;
      if (take_ident) silicon_ident_out <= rx_byte;
      if (take_data) begin
        byte_out <= rx_byte;
        if (ADDR_OUT) byte_loc <= loc_reg;
        loc_reg  <= loc_reg + ADDR_W'(1);
      end
    end
  end

  // ==========================================
  // checks
  // byte strobe: one cycle wide, a full byte apart
  a_valid_pulse: assert property (
    @(posedge core_clk) disable iff (srst) byte_valid |=> !byte_valid)
    else $error("valid longer than one cycle");
  a_byte_spacing: assert property (
    @(posedge core_clk) disable iff (srst) byte_valid && busy |=> !byte_valid [*7])
    else $error("bytes closer than eight");
  // every byte lands inside its command
  a_busy_covers: assert property (
    @(posedge core_clk) disable iff (srst) byte_valid |-> busy && $past(busy))
    else $error("byte outside command");
  a_ident_hold: assert property (
    @(posedge core_clk) disable iff (srst) !(take_reg && is_sid_reg) |=> $stable(silicon_ident_out))
    else $error("ident changed");
  a_ident_ready: assert property (
    @(posedge core_clk) disable iff (srst) take_reg && is_sid_reg |=> busy)
    else $error("ident after busy fell");
  a_data_hold: assert property (
    @(posedge core_clk) disable iff (srst) !byte_valid |-> $stable(byte_out))
    else $error("byte changed unflagged");
  a_start_busy: assert property (
    @(posedge core_clk) disable iff (srst) start |=> busy)
    else $error("busy not raised");
  a_ident_first: assert property (
    @(posedge core_clk) disable iff (srst) start && read_sid_req |=> is_sid_reg)
    else $error("priority broken");
  a_loc_step: assert property (
    @(posedge core_clk) disable iff (srst)
      byte_valid ##8 byte_valid |-> (byte_loc == $past(byte_loc, 8) + ADDR_W'(1)) || !ADDR_OUT)
    else $error("location not sequential");
  // command kind frozen while busy
  a_no_restart: assert property (
    @(posedge core_clk) disable iff (srst) busy |=> $stable(is_sid_reg))
    else $error("request taken while busy");
  a_fast_delay: assert property (
    @(posedge core_clk) disable iff (srst)
      $rose(state_reg == SFRS_DUMMY) |-> (state_reg == SFRS_DUMMY) [*8] ##1 (state_reg == SFRS_DATA))
    else $error("fast read dummy span wrong");
  a_reset_clear: assert property (
    @(posedge core_clk) srst |=> !busy && !byte_valid && byte_out == ZERO8 && silicon_ident_out == ZERO8)
    else $error("reset not cleared");
  // main scenarios
  c_ident: cover property (@(posedge core_clk) disable iff (srst) $fell(busy) && is_sid_reg);
  c_single: cover property (@(posedge core_clk) disable iff (srst) byte_valid ##1 !busy);
  c_multi: cover property (@(posedge core_clk) disable iff (srst) byte_valid ##8 byte_valid);
  c_fast: cover property (@(posedge core_clk) disable iff (srst) $rose(state_reg == SFRS_DUMMY));
  c_rerun: cover property (@(posedge core_clk) disable iff (srst) $fell(busy) ##1 $rose(busy));
endmodule // sfrs_top

// ### test/sfrs_flash_model.sv
// Purpose: behavioural serial flash answering read and ident commands
// Assumes: mode 0 style, bits taken on rising edge, data out on falling edge
// Notes:   data byte is the location low byte xor a5
`timescale 1ns/1ps
module sfrs_flash_model
  import sfrs_pkg::*;
#(
  parameter logic [7:0] IDENT = 8'h5A  // arbitrary value
) (
  // flash pins
  input  wire logic core_clk,
  input  wire logic flash_cs_n,
  input  wire logic flash_sclk_en,
  input  wire logic flash_mosi,
  output logic      flash_miso
);
  logic [31:0] hdr_reg = '0;
  int          bits_reg = 0;
  int          start;
  int          d;
  logic [7:0]  val;
  initial flash_miso = 1'b0;
  // ==========================================
  // header capture
  always @(posedge core_clk) begin
    if (flash_cs_n) bits_reg <= 0;
    else if (flash_sclk_en) begin
      if (bits_reg < 32) hdr_reg <= {hdr_reg[30:0], flash_mosi};
      bits_reg <= bits_reg + 1;
    end
  end
  // ==========================================
  // data out; released line toggles
  always @(negedge core_clk) begin
    start = (hdr_reg[31:24] == OP_FAST) ? 32 + FAST_EXTRA : 32;
    d = bits_reg - start;
    val = (hdr_reg[31:24] == OP_SID) ? IDENT : (hdr_reg[7:0] + 8'(d / 8)) ^ 8'hA5;
    if (flash_cs_n || d < 0) flash_miso <= ~flash_miso;
    else flash_miso <= val[7 - d % 8];
  end
endmodule // sfrs_flash_model

// ### test/sfrs_top_tb.sv
// Purpose: self-checking bench for the flash read sequencer
// Assumes: normal and fast builds side by side, location output on
// Notes:   inputs change on falling edge
`timescale 1ns/1ps
module sfrs_top_tb;
  import sfrs_pkg::*;
  localparam logic [7:0] IDENT = 8'h5A;  // arbitrary value
  logic              core_clk = 0, srst = 1, read_sid_req = 0, read_req = 0, fast_read_req = 0, read_cont = 0;
  logic [ADDR_W-1:0] addr_in = '0, byte_loc;
  logic [DATA_W-1:0] byte_out, silicon_ident_out;
  logic              busy, byte_valid, flash_cs_n, flash_sclk_en, flash_mosi, flash_miso;
  int                errors = 0, checks_done = 0;
  logic              f_busy, f_byte_valid, f_cs_n, f_sclk_en, f_mosi, f_miso;
  logic [DATA_W-1:0] f_byte_out, f_ident;
  logic [ADDR_W-1:0] f_loc;
  int                first_rd = 0;
  initial forever #4 core_clk = ~core_clk;
  sfrs_top dut_u (.core_clk, .srst, .read_sid_req, .read_req, .fast_read_req, .read_cont, .addr_in, .busy,
    .byte_valid, .byte_out, .byte_loc, .silicon_ident_out, .flash_cs_n, .flash_sclk_en, .flash_mosi, .flash_miso);
  sfrs_flash_model #(.IDENT(IDENT)) flash_u (.core_clk, .flash_cs_n, .flash_sclk_en, .flash_mosi, .flash_miso);
  sfrs_top #(.USE_FAST(1'b1)) fast_u (.core_clk, .srst, .read_sid_req, .read_req, .fast_read_req, .read_cont,
    .addr_in, .busy(f_busy), .byte_valid(f_byte_valid), .byte_out(f_byte_out), .byte_loc(f_loc),
    .silicon_ident_out(f_ident), .flash_cs_n(f_cs_n), .flash_sclk_en(f_sclk_en), .flash_mosi(f_mosi),
    .flash_miso(f_miso));
  sfrs_flash_model #(.IDENT(IDENT)) fflash_u (.core_clk, .flash_cs_n(f_cs_n), .flash_sclk_en(f_sclk_en),
    .flash_mosi(f_mosi), .flash_miso(f_miso));
  // ==========================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] expb(input logic [23:0] l);
    return l[7:0] ^ 8'hA5;
  endfunction
  // ==========================================
  // scenarios
  task automatic t_ident();
    int t = 0;
    int v = 0;
    read_sid_req = 1;
    read_req = 1;
    fast_read_req = 1;
    @(negedge core_clk);
    read_sid_req = 0;
    read_req = 0;
    fast_read_req = 0;
    chk("busy", 1, busy);
    while (busy === 1'b1 && t < 400) begin
      read_req = (t == 20);
      v += (byte_valid === 1'b1);
      @(negedge core_clk);
      t++;
    end
    chk("ident", IDENT, silicon_ident_out);
    chk("fident", IDENT, f_ident);
    chk("valids", 0, v);
    repeat (3) @(negedge core_clk);
    chk("busy", 0, busy);
  endtask
  task automatic t_rerun();
    int t = 0;
    read_sid_req = 1;
    @(negedge core_clk);
    while (busy === 1'b1 && t < 400) begin
      @(negedge core_clk);
      t++;
    end
    repeat (2) @(negedge core_clk);
    read_sid_req = 0;
    chk("busy", 1, busy);
    while (busy === 1'b1 && t < 800) begin
      @(negedge core_clk);
      t++;
    end
    chk("ident", IDENT, silicon_ident_out);
  endtask
  task automatic t_read(input logic [23:0] a, input int n);
    int t = 0;
    int k = 0;
    int last = 0;
    repeat (2) @(negedge core_clk);
    addr_in = a;
    read_req = 1;
    read_cont = 1;
    @(negedge core_clk);
    read_req = 0;
    if (n == 1) read_cont = 0;
    chk("busy", 1, busy);
    chk("fbusy", 0, f_busy);
    while (busy === 1'b1 && t < 1000) begin
      if (byte_valid === 1'b1) begin
        if (k == 0) first_rd = t;
        chk("byte", expb(24'(a + k)), byte_out);
        chk("loc", 24'(a + k), byte_loc);
        if (k > 0) chk("gap", 8, t - last);
        last = t;
        k++;
        if (k == n - 1) read_cont = 0;
      end
      @(negedge core_clk);
      t++;
    end
    chk("count", n, k);
    repeat (3) @(negedge core_clk);
    chk("held", expb(24'(a + n - 1)), byte_out);
  endtask
  task automatic t_fast(input logic [23:0] a, input int n);
    int t = 0;
    int k = 0;
    repeat (2) @(negedge core_clk);
    addr_in = a;
    fast_read_req = 1;
    read_cont = 1;
    @(negedge core_clk);
    fast_read_req = 0;
    chk("fbusy", 1, f_busy);
    chk("busy", 0, busy);
    while (f_busy === 1'b1 && t < 1000) begin
      if (f_byte_valid === 1'b1) begin
        if (k == 0) chk("lat", first_rd + FAST_EXTRA, t);
        chk("fbyte", expb(24'(a + k)), f_byte_out);
        chk("floc", 24'(a + k), f_loc);
        k++;
        if (k == n - 1) read_cont = 0;
      end
      @(negedge core_clk);
      t++;
    end
    chk("fcount", n, k);
    repeat (3) @(negedge core_clk);
    chk("fheld", expb(24'(a + n - 1)), f_byte_out);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(negedge core_clk);
    srst = 0;
    chk("busy", 0, busy);
    chk("ident", 0, silicon_ident_out);
    chk("byte", 0, byte_out);
    t_ident();
    t_rerun();
    t_read(24'h00_0010, 1);
    t_read(24'h00_00FE, 4);
    t_fast(24'h00_0020, 2);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
endmodule // sfrs_top_tb
